// *** src/scf_pkg.sv ***
package scf_pkg;
    // Register select codes on the control register port
    localparam logic [1:0] SEL_PAGE_BASE = 2'h0;
    localparam logic [1:0] SEL_FEATURE = 2'h1;
    localparam logic [1:0] SEL_PRIORITY = 2'h2;
    // Page-table-base field positions
    localparam int PTB_WRITE_THROUGH = 3;
    // Feature control field positions
    localparam int FC_V86_EXT = 0;
    localparam int FC_PROT_VINT = 1;
    localparam int FC_TS_RESTRICT = 2;
    localparam int FC_DEBUG_EXT = 3;
    localparam int FC_LARGE_PAGE = 4;
    localparam int FC_PHYS_EXT = 5;
    localparam int FC_MCHK = 6;
    localparam int FC_GLOBAL_PAGE = 7;
    localparam int FC_PERF_READ = 8;
    localparam int FC_FAST_SAVE = 9;
    localparam int FC_SIMD_EXC = 10;
    localparam int FC_VM_EXT = 13;
    localparam int FC_SAFER = 14;
    localparam int FC_CTX_ID = 17;
    localparam int FC_EXT_SAVE = 18;
    // Feature identification bit that mirrors the extended save enable
    localparam int ID_EXT_SAVE_BIT = 27;
    // Implemented feature control bits
    localparam logic [31:0] FC_IMPL_MASK = 32'h0006_67FF;
    // Priority threshold field
    localparam int PRIO_MSB = 3;
    localparam logic [3:0] PRIO_BLOCK_ALL = 4'hF;
    // Reset values
    localparam logic [31:0] PTB_RESET = 32'h0000_0000;
    localparam logic [31:0] FC_RESET = 32'h0000_0000;
    localparam logic [3:0] PRIO_RESET = 4'h0;
    // Privilege levels
    localparam logic [1:0] PRIV_KERNEL = 2'h0;
    // Physical address width limits without and with extension
    localparam int PA_NARROW = 32;
    localparam int PA_WIDE = 52;
    // Page sizes, log2 of bytes
    localparam logic [4:0] PAGE_SMALL_LOG2 = 5'h0C;
    localparam logic [4:0] PAGE_LARGE_LOG2 = 5'h16;
endpackage

// *** src/scf_system_control_flag_decode.sv ***
// Contract
// - Page-base bit 3 selects write-through when set, write-back when clear.
// - Write-through flag ignored when paging is off or caches are disabled.
// - Feature bit 0 enables virtual-8086 interrupt and exception extensions.
// - Feature bit 1 enables protected-mode virtual interrupt flag support.
// - Feature bit 2 restricts timestamp reads to privilege level 0.
// - Feature bit 3 makes debug registers four and five fault, else alias.
// - Feature bit 4 permits large pages under 32-bit paging.
// - Feature bit 5 allows physical addresses wider than 32 bits.
// - Feature bit 6 enables the machine-check exception.
// - Feature bit 7 keeps global translations across task switch and base write.
// - Feature bit 8 allows counter reads at any level, else level 0 only.
// - Feature bit 9 adds vector state to fast save and enables SIMD.
// - With bit 9 clear SIMD faults except listed exempt instructions.
// - Feature bit 10 routes unmasked SIMD faults to SIMD vector, else undefined.
// - Feature bit 13 enables virtual-machine extension operation.
// - Feature bit 14 enables safer-mode extension operation.
// - Feature bit 17 enables context ids; settable only in 64-bit mode.
// - Feature bit 18 mirrored to id bit 27, enables extended save and mask access.
// - Priority bits 3:0 block interrupts at or below threshold; 0 none, 15 all.
// - Feature flags except counter enable are reported via identification.
`timescale 1ns/100ps
module scf_system_control_flag_decode
    import scf_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Control register port
    input wire logic regWrite,
    input wire logic [1:0] regSel,
    input wire logic [31:0] regWdata,
    output logic [31:0] regRdata,
    output logic regWriteFault,
    // Core mode context
    input wire logic pagingEnable,
    input wire logic cacheDisableFlag,
    input wire logic longModeActive,
    input wire logic [1:0] curPriv,
    input wire logic v86Mode,
    input wire logic protMode,
    // Instruction classification from decode
    input wire logic isTimestampRead,
    input wire logic isPerfCounterRead,
    input wire logic isDebugRegFourFive,
    input wire logic isSimdInstr,
    input wire logic isSimdExempt,
    input wire logic isFeatureMaskAccess,
    input wire logic isExtStateSaveRestore,
    input wire logic simdFpUnmaskedFault,
    input wire logic machineCheckEvent,
    input wire logic taskSwitchEvent,
    input wire logic [3:0] pendingIntPriority,
    // Decoded effects
    output logic writeThroughActive,
    output logic cachePolicyValid,
    output logic v86ExtensionsActive,
    output logic protVirtIntActive,
    output logic undefinedOpcodeFault,
    output logic privFault,
    output logic simdFpExceptionRaise,
    output logic machineCheckRaise,
    output logic debugRegAlias,
    output logic largePageAllowed,
    output logic [5:0] physAddrWidth,
    output logic tlbFlushAll,
    output logic tlbFlushNonGlobal,
    output logic fastSaveVector,
    output logic vmExtensionsActive,
    output logic saferModeActive,
    output logic contextIdActive,
    output logic [31:0] featureIdReport,
    output logic interruptBlocked,
    output logic [4:0] pageSizeLog2Max
);
    typedef struct packed {
        logic [31:0] pageBase;
        logic [31:0] feature;
        logic [3:0] prio;
        logic [31:0] rdata;
        logic wfault;
        logic wt;
        logic cpValid;
        logic v86;
        logic protected_virtual_interrupts;
        logic ud;
        logic gp;
        logic xf;
        logic mc;
        logic alias4;
        logic lp;
        logic [5:0] paw;
        logic flushAll;
        logic flushNg;
        logic fsv;
        logic vmx;
        logic smx;
        logic cid;
        logic [31:0] idRep;
        logic blk;
        logic [4:0] pgMax;
    } scf_state_t;

    scf_state_t st_reg;
    scf_state_t st_next;
    logic [31:0] fcWr;
    logic [31:0] fcNew;
    logic ptbWrite;

    // Write decode of the register select
    logic wrPage;
    logic wrFeature;
    logic wrPriority;
    logic wrUnmapped;
    logic ctxIdRefused;

    // Named flags of the feature value in force
    logic fV86Ext;
    logic fProtVint;
    logic fTsRestrict;
    logic fDebugExt;
    logic fLargePage;
    logic fPhysExt;
    logic fMchk;
    logic fGlobalPage;
    logic fPerfRead;
    logic fFastSave;
    logic fSimdExc;
    logic fVmExt;
    logic fSafer;
    logic fCtxId;
    logic fExtSave;

    // Exception and privilege source terms
    logic notKernel;
    logic udDebug;
    logic udSimd;
    logic udSimdFp;
    logic udMaskAccess;
    logic udStateSave;
    logic tsRefused;
    logic perfRefused;

    // Priority threshold terms
    logic prioNone;
    logic prioAll;
    logic prioHit;

    // Next state: register writes and decoded effects
    always_comb begin
        st_next = st_reg;
        fcWr = regWdata & FC_IMPL_MASK;
        fcNew = st_reg.feature;
        ptbWrite = 1'b0;
        wrPage = 1'b0;
        wrFeature = 1'b0;
        wrPriority = 1'b0;
        wrUnmapped = 1'b0;

        // Register select decode
        if (regSel == SEL_PAGE_BASE) begin
            wrPage = regWrite;
        end else if (regSel == SEL_FEATURE) begin
            wrFeature = regWrite;
        end else if (regSel == SEL_PRIORITY) begin
            wrPriority = regWrite;
        end else begin
            wrUnmapped = regWrite;
        end

        // Context ids only switch on in 64-bit mode; a refused write is dropped whole
        ctxIdRefused = wrFeature && fcWr[FC_CTX_ID] && !longModeActive;

        // Register updates
        if (wrPage) begin
            st_next.pageBase = regWdata;
            ptbWrite = 1'b1;
        end
        if (wrFeature && !ctxIdRefused) begin
            fcNew = fcWr;
        end
        if (wrPriority) begin
            st_next.prio = regWdata[PRIO_MSB:0];
        end
        st_next.feature = fcNew;
        st_next.wfault = ctxIdRefused || wrUnmapped;

        // Read mux; the feature read shows implemented bits only
        if (regSel == SEL_PAGE_BASE) begin
            st_next.rdata = st_next.pageBase;
        end else if (regSel == SEL_FEATURE) begin
            st_next.rdata = st_next.feature;
        end else if (regSel == SEL_PRIORITY) begin
            st_next.rdata = {28'h000_0000, st_next.prio};
        end else begin
            st_next.rdata = 32'h0000_0000;
        end

        // Flags of the feature value including a same-cycle write
        fV86Ext = fcNew[FC_V86_EXT];
        fProtVint = fcNew[FC_PROT_VINT];
        fTsRestrict = fcNew[FC_TS_RESTRICT];
        fDebugExt = fcNew[FC_DEBUG_EXT];
        fLargePage = fcNew[FC_LARGE_PAGE];
        fPhysExt = fcNew[FC_PHYS_EXT];
        fMchk = fcNew[FC_MCHK];
        fGlobalPage = fcNew[FC_GLOBAL_PAGE];
        fPerfRead = fcNew[FC_PERF_READ];
        fFastSave = fcNew[FC_FAST_SAVE];
        fSimdExc = fcNew[FC_SIMD_EXC];
        fVmExt = fcNew[FC_VM_EXT];
        fSafer = fcNew[FC_SAFER];
        fCtxId = fcNew[FC_CTX_ID];
        fExtSave = fcNew[FC_EXT_SAVE];

        // Cache policy of the top paging structure, void without paging or caches
        st_next.cpValid = pagingEnable && !cacheDisableFlag;
        if (st_next.cpValid && st_next.pageBase[PTB_WRITE_THROUGH]) begin
            st_next.wt = 1'b1;
        end else begin
            st_next.wt = 1'b0;
        end

        // Virtual interrupt support in virtual-8086 and protected mode
        st_next.v86 = 1'b0;
        st_next.protected_virtual_interrupts = 1'b0;
        if (v86Mode) begin
            st_next.v86 = fV86Ext;
        end else if (protMode) begin
            st_next.protected_virtual_interrupts = fProtVint;
        end

        // Undefined-opcode sources
        udDebug = isDebugRegFourFive && fDebugExt;
        udSimd = isSimdInstr && !isSimdExempt && !fFastSave;
        udSimdFp = simdFpUnmaskedFault && !fSimdExc;
        udMaskAccess = isFeatureMaskAccess && !fExtSave;
        udStateSave = isExtStateSaveRestore && !fExtSave;
        st_next.ud = udDebug
            || udSimd
            || udSimdFp
            || udMaskAccess
            || udStateSave;
        st_next.alias4 = isDebugRegFourFive && !fDebugExt;

        // Timestamp and counter reads outside level 0
        notKernel = curPriv != PRIV_KERNEL;
        tsRefused = 1'b0;
        if (isTimestampRead && fTsRestrict && notKernel) begin
            tsRefused = 1'b1;
        end
        perfRefused = 1'b0;
        if (isPerfCounterRead && !fPerfRead && notKernel) begin
            perfRefused = 1'b1;
        end
        st_next.gp = tsRefused || perfRefused;

        // Exception routing
        st_next.xf = simdFpUnmaskedFault && fSimdExc;
        st_next.mc = machineCheckEvent && fMchk;

        // Paging shape
        st_next.lp = fLargePage;
        if (fLargePage) begin
            st_next.pgMax = PAGE_LARGE_LOG2;
        end else begin
            st_next.pgMax = PAGE_SMALL_LOG2;
        end
        if (fPhysExt) begin
            st_next.paw = 6'(PA_WIDE);
        end else begin
            st_next.paw = 6'(PA_NARROW);
        end

        // TLB flush on task switch or base write; global entries kept when enabled
        st_next.flushNg = ptbWrite || taskSwitchEvent;
        if (fGlobalPage) begin
            st_next.flushAll = 1'b0;
        end else begin
            st_next.flushAll = st_next.flushNg;
        end

        // Plain enables
        st_next.fsv = fFastSave;
        st_next.vmx = fVmExt;
        st_next.smx = fSafer;
        st_next.cid = fCtxId;

        // Identification report; counter enable is not reported
        st_next.idRep = fcNew & FC_IMPL_MASK & ~(32'h0000_0001 << FC_PERF_READ);
        st_next.idRep[ID_EXT_SAVE_BIT] = fExtSave;

        // Interrupt threshold: block priorities at or below the field, none when the field is 0
        prioNone = st_next.prio == 4'h0;
        prioAll = st_next.prio == PRIO_BLOCK_ALL;
        prioHit = pendingIntPriority <= st_next.prio;
        if (prioAll) begin
            st_next.blk = 1'b1;
        end else if (prioNone) begin
            st_next.blk = 1'b0;
        end else begin
            st_next.blk = prioHit;
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.pageBase <= PTB_RESET;
            st_reg.feature <= FC_RESET;
            st_reg.prio <= PRIO_RESET;
            st_reg.pgMax <= PAGE_SMALL_LOG2;
            st_reg.paw <= 6'(PA_NARROW);
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from flops
    assign regRdata = st_reg.rdata;
    assign regWriteFault = st_reg.wfault;
    assign writeThroughActive = st_reg.wt;
    assign cachePolicyValid = st_reg.cpValid;
    assign v86ExtensionsActive = st_reg.v86;
    assign protVirtIntActive = st_reg.protected_virtual_interrupts;
    assign undefinedOpcodeFault = st_reg.ud;
    assign privFault = st_reg.gp;
    assign simdFpExceptionRaise = st_reg.xf;
    assign machineCheckRaise = st_reg.mc;
    assign debugRegAlias = st_reg.alias4;
    assign largePageAllowed = st_reg.lp;
    assign physAddrWidth = st_reg.paw;
    assign tlbFlushAll = st_reg.flushAll;
    assign tlbFlushNonGlobal = st_reg.flushNg;
    assign fastSaveVector = st_reg.fsv;
    assign vmExtensionsActive = st_reg.vmx;
    assign saferModeActive = st_reg.smx;
    assign contextIdActive = st_reg.cid;
    assign featureIdReport = st_reg.idRep;
    assign interruptBlocked = st_reg.blk;
    assign pageSizeLog2Max = st_reg.pgMax;
endmodule

// *** verification/scf_flag_asserts.sv ***
`timescale 1ns/100ps
module scf_flag_asserts
    import scf_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic regWrite,
    input wire logic [1:0] regSel,
    input wire logic [31:0] regWdata,
    input wire logic regWriteFault,
    input wire logic [31:0] featureIdReport,
    // Core context
    input wire logic longModeActive,
    input wire logic pagingEnable,
    input wire logic cacheDisableFlag,
    input wire logic machineCheckEvent,
    input wire logic isDebugRegFourFive,
    input wire logic taskSwitchEvent,
    // Effects
    input wire logic cachePolicyValid,
    input wire logic writeThroughActive,
    input wire logic machineCheckRaise,
    input wire logic debugRegAlias,
    input wire logic tlbFlushAll,
    input wire logic tlbFlushNonGlobal,
    input wire logic [5:0] physAddrWidth
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // Effects follow their cause one cycle later
    property p_gate;
        !$past(rst) |-> cachePolicyValid == $past(pagingEnable && !cacheDisableFlag);
    endproperty
    a_gate: assert property (p_gate) else $error("policy gate");
    property p_wt;
        writeThroughActive |-> cachePolicyValid;
    endproperty
    a_wt: assert property (p_wt) else $error("write-through ungated");
    property p_mchk;
        !$past(rst) |-> machineCheckRaise == ($past(machineCheckEvent) && featureIdReport[6]);
    endproperty
    a_mchk: assert property (p_mchk) else $error("machine check");
    property p_alias;
        !$past(rst) |-> debugRegAlias == ($past(isDebugRegFourFive) && !featureIdReport[3]);
    endproperty
    a_alias: assert property (p_alias) else $error("debug alias");
    property p_pa;
        physAddrWidth == (featureIdReport[FC_PHYS_EXT] ? PA_WIDE : PA_NARROW);
    endproperty
    a_pa: assert property (p_pa) else $error("address width");
    property p_flush;
        !$past(rst) |-> tlbFlushNonGlobal == $past(taskSwitchEvent || regWrite && regSel == 0);
    endproperty
    a_flush: assert property (p_flush) else $error("tlb flush");
    property p_global;
        tlbFlushAll == (tlbFlushNonGlobal && !featureIdReport[FC_GLOBAL_PAGE]);
    endproperty
    a_global: assert property (p_global) else $error("global flush");
    property p_ctx;
        regWrite && regSel == SEL_FEATURE && regWdata[17] && !longModeActive
            |=> regWriteFault && $stable(featureIdReport);
    endproperty
    a_ctx: assert property (p_ctx) else $error("context id write");
    property p_id;
        (featureIdReport & ~FC_IMPL_MASK) == {4'h0, featureIdReport[18], 27'h0}
            && !featureIdReport[FC_PERF_READ];
    endproperty
    a_id: assert property (p_id) else $error("id report");
    // Main scenarios
    c_fault: cover property (regWriteFault);
    c_mchk: cover property (machineCheckRaise);
    c_keep: cover property (tlbFlushNonGlobal && !tlbFlushAll);
endmodule
bind scf_system_control_flag_decode scf_flag_asserts i_chk (.*);

// *** verification/system_control_flag_decode_test.sv ***
`timescale 1ns/100ps
module system_control_flag_decode_test
    import scf_pkg::*;
();
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic regWrite, pagingEnable, cacheDisableFlag, longModeActive, v86Mode, protMode;
    logic isTimestampRead, isPerfCounterRead, isDebugRegFourFive, isSimdInstr, isSimdExempt;
    logic isFeatureMaskAccess, isExtStateSaveRestore, simdFpUnmaskedFault, machineCheckEvent;
    logic taskSwitchEvent, regWriteFault, writeThroughActive, cachePolicyValid;
    logic v86ExtensionsActive, protVirtIntActive, undefinedOpcodeFault, privFault;
    logic simdFpExceptionRaise, machineCheckRaise, debugRegAlias, largePageAllowed;
    logic tlbFlushAll, tlbFlushNonGlobal, fastSaveVector, vmExtensionsActive;
    logic saferModeActive, contextIdActive, interruptBlocked;
    logic [1:0] regSel, curPriv;
    logic [3:0] pendingIntPriority, blk = 4'b0110;
    logic [3:0] thr[4] = '{4'h0, 4'hF, 4'h5, 4'h5};
    logic [3:0] pend[4] = '{4'hF, 4'h0, 4'h5, 4'h6};
    logic [4:0] pageSizeLog2Max;
    logic [5:0] physAddrWidth;
    logic [10:0] fx, e;
    logic [31:0] regWdata, regRdata, featureIdReport, f;
    int miscompares = 0;
    int checks_done = 0;
    int bits[14] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 13, 14, 18};
    scf_system_control_flag_decode i_dut (.*);
    // Flag effects gathered for one compare
    assign fx = {v86ExtensionsActive, protVirtIntActive, undefinedOpcodeFault, privFault,
        simdFpExceptionRaise, machineCheckRaise, largePageAllowed, fastSaveVector,
        vmExtensionsActive, saferModeActive, contextIdActive};
    always #2 ref_clk = ~ref_clk;
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(string name, logic [63:0] seen, logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(logic [1:0] sel, logic [31:0] data);
        // Idle edge first, so the strobe never falls and rises in one time step
        tick();
        regWrite = 1'b1;
        regSel = sel;
        regWdata = data;
        tick();
        regWrite = 1'b0;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Watchdog against a hung run
    initial begin
        #20000;
        miscompares++;
        final_report();
    end
    // Main sequence
    initial begin
        {regWrite, pagingEnable, cacheDisableFlag, longModeActive, v86Mode, protMode,
            isTimestampRead, isPerfCounterRead, isDebugRegFourFive, isSimdInstr, isSimdExempt,
            isFeatureMaskAccess, isExtStateSaveRestore, simdFpUnmaskedFault, machineCheckEvent,
            taskSwitchEvent, regSel, curPriv, pendingIntPriority, regWdata} = '0;
        repeat (6) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        chk("pa rst", physAddrWidth, PA_NARROW);
        pagingEnable = 1'b1;
        wr(SEL_FEATURE, 32'h0000_0020);
        chk("pa ext", physAddrWidth, PA_WIDE);
        longModeActive = 1'b1;
        wr(SEL_FEATURE, 32'hFFFF_FFFF);
        chk("fc all", regRdata, FC_IMPL_MASK);
        chk("ctx", contextIdActive, 1'b1);
        longModeActive = 1'b0;
        wr(SEL_FEATURE, 32'h0002_0000);
        chk("ctx drop", {regWriteFault, regRdata}, {1'b1, FC_IMPL_MASK});
        wr(2'h3, 32'h0);
        chk("unmapped", regWriteFault, 1'b1);
        {isSimdInstr, simdFpUnmaskedFault, isFeatureMaskAccess, isTimestampRead,
            isPerfCounterRead, machineCheckEvent, protMode, curPriv} = '1;
        foreach (bits[k]) begin
            f = FC_IMPL_MASK & ~32'h0002_0000 & ~(32'h1 << bits[k]);
            v86Mode = !bits[k][0];
            wr(SEL_FEATURE, f);
            e = {v86Mode & f[0], !v86Mode & f[1], !(f[9] & f[10] & f[18]), f[2] | !f[8],
                f[10], f[6], f[4], f[9], f[13], f[14], f[17]};
            chk("fx", fx, e);
            chk("fc", regRdata, f);
            chk("id", featureIdReport, f & ~32'h0000_0100 | {4'h0, f[18], 27'h0});
            chk("pg", pageSizeLog2Max, f[4] ? PAGE_LARGE_LOG2 : PAGE_SMALL_LOG2);
            chk("pa", physAddrWidth, f[5] ? PA_WIDE : PA_NARROW);
        end
        curPriv = PRIV_KERNEL;
        tick();
        chk("pf kernel", privFault, 1'b0);
        {isSimdInstr, simdFpUnmaskedFault, isFeatureMaskAccess, isDebugRegFourFive} = 4'h1;
        wr(SEL_FEATURE, 32'h8);
        chk("dr set", {undefinedOpcodeFault, debugRegAlias}, 2'b10);
        wr(SEL_FEATURE, 32'h0);
        chk("dr clr", {undefinedOpcodeFault, debugRegAlias}, 2'b01);
        pagingEnable = 1'b1;
        wr(SEL_PAGE_BASE, 32'h8);
        chk("wt", {writeThroughActive, cachePolicyValid, tlbFlushNonGlobal, tlbFlushAll,
            regRdata}, {4'hF, 32'h8});
        cacheDisableFlag = 1'b1;
        tick();
        chk("wt cd", {writeThroughActive, cachePolicyValid}, 2'b00);
        {pagingEnable, cacheDisableFlag} = 2'b00;
        tick();
        chk("wt pg", {writeThroughActive, cachePolicyValid}, 2'b00);
        pagingEnable = 1'b1;
        wr(SEL_FEATURE, 32'h80);
        taskSwitchEvent = 1'b1;
        tick();
        taskSwitchEvent = 1'b0;
        chk("global", {tlbFlushNonGlobal, tlbFlushAll}, 2'b10);
        for (int k = 0; k < 4; k++) begin
            pendingIntPriority = pend[k];
            wr(SEL_PRIORITY, {28'hFFF_FFFF, thr[k]});
            chk("prio", regRdata, {28'h0, thr[k]});
            chk("blk", interruptBlocked, blk[k]);
        end
        final_report();
    end
endmodule
